// ### core/omc_defs.svh
// register offsets, field positions and constants of the mode controller
`ifndef OMC_DEFS_SVH
`define OMC_DEFS_SVH
`define OMC_CTRL_OFS 4'h0
`define OMC_STAT_OFS 4'h4
`define OMC_CTRL_STOPEN 0
`define OMC_CTRL_PPDSEL 1
`define OMC_CTRL_LVDEN 2
`define OMC_CTRL_LVSEN 3
`define OMC_CTRL_DBGEN 4
`define OMC_CTRL_PWS_LO 5
`define OMC_CTRL_PWS_HI 7
`define OMC_STAT_PDFLAG 0
`define OMC_STAT_LATCHED 1
`define OMC_STAT_MODE_LO 4
`define OMC_STAT_MODE_HI 6
`define OMC_STAT_PDACK 0
`define OMC_CTRL_RESET 8'h00
`define OMC_RESET_VEC 16'hfffe
`define OMC_PWS_OFF 3'h0
`endif

// ### core/omc_pkg.sv
// types of the operating mode controller
package omc_pkg;
  typedef enum logic [2:0] {
    OMC_ST_RESET, OMC_ST_RUN, OMC_ST_DEBUG_SERIAL_PIN, OMC_ST_WAIT, OMC_ST_STOP2,
    OMC_ST_STOP3
  } omc_mode_t;
  typedef enum logic [2:0] {
    OMC_CMD_MEM, OMC_CMD_MEM_STAT, OMC_CMD_DBG_REG, OMC_CMD_BACKGROUND,
    OMC_CMD_CPU_REG, OMC_CMD_TRACE, OMC_CMD_GO
  } omc_cmd_t;
endpackage : omc_pkg

// ### core/omc_top.sv
// operating mode controller: run, background, wait and two stop modes
//
// The register addresses and the Avalon-MM slave port were decided locally.
`include "omc_defs.svh"

// How it works
// - mode pin high at reset release enters run and fetches vector 0xfffe.
// - background entered by pin low, command, break instruction, breakpoints.
// - in background the cpu stays suspended, awaiting serial commands.
// - non-intrusive commands are accepted in run and in background.
// - active background commands execute only in background mode.
// - wait stops the cpu clock, system clocks run, interrupt mask cleared.
// - any interrupt in wait resumes the cpu with interrupt stacking.
// - in wait only background and status commands; status returns error.
// - background command in wait wakes into background mode.
// - stop with stop enable set enters one of two stop modes.
// - stop with stop enable clear forces an illegal opcode reset.
// - partial power-down select 1 picks stop2, 0 picks stop3.
// - low-voltage detect and stop enable both set force stop3.
// - stop2 entry latches all pins and powers down all but ram.
// - pins stay latched until software writes acknowledge 1.
// - stop2 exits only by reset pin, irq pin low or periodic wake.
// - stop2 wake restarts as power-on, reset vector, pins still latched.
// - stop2 wake sets powerdown flag until acknowledge written.
// - opened latches pass the current port drive to the pins.
// - periodic wake select zero disables the source and its wakeup.
// - stop3 halts cpu and system clocks and oscillator, keeps all state.
// - stop3 exits by reset pin or listed interrupts, with vectors.
// - debug enable keeps debug clocks in stop and turns stop2 into stop3.
module omc_top (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // pins and cpu events
  input wire logic reset_pin_n,
  input wire logic mode_select_pin,
  input wire logic break_to_debug_instruction,
  input wire logic debug_controller_bkpt,
  input wire logic on_chip_debug_module_bkpt,
  input wire logic wait_instr,
  input wire logic stop_instr,
  input wire logic irq_req,
  input wire logic [15:0] irq_vec,
  // wake sources
  input wire logic ext_irq_pin,
  input wire logic keypad_interrupt_pins,
  input wire logic periodic_wake_interrupt,
  input wire logic sci_rx_wake,
  input wire logic adc_wake,
  input wire logic lowvolt_interrupt,
  // debug commands from the serial engine
  input wire logic cmd_valid,
  input wire omc_pkg::omc_cmd_t cmd_code,
  output logic cmd_done,
  output logic cmd_err,
  output logic trace_step,
  // pins
  input wire logic [7:0] pin_drive,
  output logic [7:0] pin_out,
  // mode and power outputs
  output omc_pkg::omc_mode_t mode,
  output logic cpu_clk_en,
  output logic sys_clk_en,
  output logic dbg_clk_en,
  output logic osc_en,
  output logic power_down,
  output logic periodic_wake_osc_en,
  output logic pins_latched,
  output logic powerdown_flag,
  output logic ccr_i_clear,
  output logic int_stack_start,
  output logic vec_fetch,
  output logic [15:0] vec_addr,
  output logic illegal_op_reset,
  output logic por_restart
);
  import omc_pkg::*;

  typedef struct packed {
    omc_mode_t st;
    logic pwo;
    logic wait_q;
    logic [7:0] rdata;
    logic [7:0] ctrl;
    logic pdflag;
    logic latched;
    logic [7:0] hold;
    logic [7:0] pin_q;
    logic cpu_clk;
    logic sys_clk;
    logic dbg_clk;
    logic osc;
    logic pdown;
    logic done;
    logic err;
    logic trace;
    logic iclr;
    logic stack;
    logic vfetch;
    logic [15:0] vaddr;
    logic illegal;
    logic por;
  } omc_state_t;

  omc_state_t s_reg;
  omc_state_t s_next;

  logic req;
  logic bus_done;
  logic ack_wr;
  logic stop_en;
  logic dbg_en;
  logic pws_on;
  logic goto_stop2;
  logic nonintr;
  logic abg_cmd;
  logic any_irq3;

  assign req = avs_read | avs_write;
  // a request completes on the edge where waitrequest is seen low
  assign bus_done = req & ~s_reg.wait_q;
  assign ack_wr = bus_done & avs_write & avs_byteenable[0]
    & (avs_address == `OMC_STAT_OFS)
    & avs_writedata[`OMC_STAT_PDACK];
  assign stop_en = s_reg.ctrl[`OMC_CTRL_STOPEN];
  assign dbg_en = s_reg.ctrl[`OMC_CTRL_DBGEN];
  assign pws_on = s_reg.ctrl[`OMC_CTRL_PWS_HI:`OMC_CTRL_PWS_LO] != `OMC_PWS_OFF;
  assign goto_stop2 = s_reg.ctrl[`OMC_CTRL_PPDSEL]
    & ~(s_reg.ctrl[`OMC_CTRL_LVDEN] & s_reg.ctrl[`OMC_CTRL_LVSEN])
    & ~dbg_en;
  assign nonintr = cmd_code inside {OMC_CMD_MEM, OMC_CMD_MEM_STAT,
    OMC_CMD_DBG_REG, OMC_CMD_BACKGROUND};
  assign abg_cmd = cmd_code inside {OMC_CMD_CPU_REG, OMC_CMD_TRACE,
    OMC_CMD_GO};
  assign any_irq3 = ~ext_irq_pin | keypad_interrupt_pins | sci_rx_wake
    | adc_wake | lowvolt_interrupt | (periodic_wake_interrupt & pws_on);

  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.err = 1'b0;
    s_next.trace = 1'b0;
    s_next.iclr = 1'b0;
    s_next.stack = 1'b0;
    s_next.vfetch = 1'b0;
    s_next.illegal = 1'b0;
    s_next.por = 1'b0;
    // register bus: one wait cycle, then answer
    s_next.wait_q = ~(req & s_reg.wait_q);
    if (req & s_reg.wait_q)
    begin
      unique case (avs_address)
        `OMC_CTRL_OFS: s_next.rdata = s_reg.ctrl;
        `OMC_STAT_OFS: s_next.rdata = {1'b0, 3'(s_reg.st), 2'h0,
          s_reg.latched, s_reg.pdflag};
        default: s_next.rdata = 8'h00;
      endcase
    end
    if (bus_done & avs_write & avs_byteenable[0]
      & (avs_address == `OMC_CTRL_OFS))
      s_next.ctrl = avs_writedata[7:0];
    // acknowledge opens the latches and clears the flag
    if (ack_wr)
    begin
      s_next.latched = 1'b0;
      s_next.pdflag = 1'b0;
    end
    // commands from the serial engine
    if (cmd_valid)
    begin
      unique case (s_reg.st)
        OMC_ST_RUN: s_next.done = nonintr;
        OMC_ST_DEBUG_SERIAL_PIN:
        begin
          s_next.done = 1'b1;
          s_next.trace = (cmd_code == OMC_CMD_TRACE);
        end
        OMC_ST_WAIT, OMC_ST_STOP2, OMC_ST_STOP3:
          s_next.err = (cmd_code == OMC_CMD_MEM_STAT);
        default: ;
      endcase
    end
    unique case (s_reg.st)
      OMC_ST_RESET:
        if (reset_pin_n)
        begin
          s_next.vfetch = mode_select_pin;
          s_next.vaddr = `OMC_RESET_VEC;
          s_next.st = mode_select_pin ? OMC_ST_RUN : OMC_ST_DEBUG_SERIAL_PIN;
        end
      OMC_ST_RUN:
        if (cmd_valid & cmd_code == OMC_CMD_BACKGROUND
          | break_to_debug_instruction | debug_controller_bkpt
          | on_chip_debug_module_bkpt)
          s_next.st = OMC_ST_DEBUG_SERIAL_PIN;
        else if (wait_instr)
        begin
          s_next.st = OMC_ST_WAIT;
          s_next.iclr = 1'b1;
        end
        else if (stop_instr & ~stop_en)
        begin
          s_next.illegal = 1'b1;
          s_next.st = OMC_ST_RESET;
        end
        else if (stop_instr)
        begin
          s_next.st = goto_stop2 ? OMC_ST_STOP2 : OMC_ST_STOP3;
          if (goto_stop2)
          begin
            s_next.latched = 1'b1;
            s_next.hold = s_reg.pin_q;
          end
        end
      OMC_ST_DEBUG_SERIAL_PIN:
        if (cmd_valid & cmd_code == OMC_CMD_GO)
          s_next.st = OMC_ST_RUN;
      OMC_ST_WAIT:
        if (cmd_valid & cmd_code == OMC_CMD_BACKGROUND)
          s_next.st = OMC_ST_DEBUG_SERIAL_PIN;
        else if (irq_req)
        begin
          s_next.st = OMC_ST_RUN;
          s_next.stack = 1'b1;
        end
      OMC_ST_STOP2:
        if (~ext_irq_pin | (periodic_wake_interrupt & pws_on))
        begin
          s_next.st = OMC_ST_RESET;
          s_next.por = 1'b1;
          s_next.ctrl = `OMC_CTRL_RESET;
          s_next.pdflag = 1'b1;
        end
      OMC_ST_STOP3:
        if (cmd_valid & cmd_code == OMC_CMD_BACKGROUND & dbg_en)
          s_next.st = OMC_ST_DEBUG_SERIAL_PIN;
        else if (any_irq3)
        begin
          s_next.st = OMC_ST_RUN;
          s_next.stack = 1'b1;
          s_next.vfetch = 1'b1;
          s_next.vaddr = irq_vec;
        end
    endcase
    // reset pin low overrides every mode, stop modes included
    if (~reset_pin_n)
      s_next.st = OMC_ST_RESET;
    // the pin forces reset at once, so the exit must be caught while low
    if (~reset_pin_n & s_reg.st == OMC_ST_STOP2)
    begin
      s_next.por = 1'b1;
      s_next.ctrl = `OMC_CTRL_RESET;
      s_next.pdflag = 1'b1;
    end
    // pins pass the live drive only while the latches are open
    s_next.pin_q = s_next.latched ? s_next.hold : pin_drive;
    s_next.cpu_clk = s_next.st inside {OMC_ST_RUN, OMC_ST_DEBUG_SERIAL_PIN};
    s_next.sys_clk = ~(s_next.st inside {OMC_ST_STOP2, OMC_ST_STOP3});
    s_next.osc = s_next.sys_clk;
    s_next.dbg_clk = s_next.sys_clk | dbg_en;
    s_next.pdown = s_next.st == OMC_ST_STOP2;
    s_next.pwo = s_next.ctrl[`OMC_CTRL_PWS_HI:`OMC_CTRL_PWS_LO]
      != `OMC_PWS_OFF;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      s_reg <= '0;
      s_reg.st <= OMC_ST_RESET;
      s_reg.wait_q <= 1'b1;
      s_reg.ctrl <= `OMC_CTRL_RESET;
      s_reg.sys_clk <= 1'b1;
      s_reg.osc <= 1'b1;
      s_reg.dbg_clk <= 1'b1;
    end
    else if (ce)
      s_reg <= s_next;
  end

  assign avs_readdata = {24'h000000, s_reg.rdata};
  assign avs_waitrequest = s_reg.wait_q;
  assign cmd_done = s_reg.done;
  assign cmd_err = s_reg.err;
  assign trace_step = s_reg.trace;
  assign pin_out = s_reg.pin_q;
  assign mode = s_reg.st;
  assign cpu_clk_en = s_reg.cpu_clk;
  assign sys_clk_en = s_reg.sys_clk;
  assign dbg_clk_en = s_reg.dbg_clk;
  assign osc_en = s_reg.osc;
  assign power_down = s_reg.pdown;
  assign periodic_wake_osc_en = s_reg.pwo;
  assign pins_latched = s_reg.latched;
  assign powerdown_flag = s_reg.pdflag;
  assign ccr_i_clear = s_reg.iclr;
  assign int_stack_start = s_reg.stack;
  assign vec_fetch = s_reg.vfetch;
  assign vec_addr = s_reg.vaddr;
  assign illegal_op_reset = s_reg.illegal;
  assign por_restart = s_reg.por;

  a_run_vec_fetch: assert property (@(posedge ref_clk) disable iff (srst)
    ce & s_reg.st == OMC_ST_RESET & reset_pin_n & mode_select_pin |=>
    mode == OMC_ST_RUN & vec_fetch & vec_addr == 16'hfffe)
    else $error("run entry without reset vector fetch");
  a_pin_low_debug_serial_pin: assert property (@(posedge ref_clk) disable iff (srst)
    ce & s_reg.st == OMC_ST_RESET & reset_pin_n & ~mode_select_pin |=>
    mode == OMC_ST_DEBUG_SERIAL_PIN & ~vec_fetch)
    else $error("mode pin low did not enter background");
  a_debug_serial_pin_cpu_held: assert property (@(posedge ref_clk) disable iff (srst)
    mode == OMC_ST_DEBUG_SERIAL_PIN & ce & ~(cmd_valid & cmd_code == OMC_CMD_GO)
    & reset_pin_n |=> mode == OMC_ST_DEBUG_SERIAL_PIN)
    else $error("background left without resume command");
  a_wait_entry: assert property (@(posedge ref_clk) disable iff (srst)
    ce & mode == OMC_ST_RUN & wait_instr & ~stop_instr & reset_pin_n
    & ~break_to_debug_instruction & ~debug_controller_bkpt
    & ~on_chip_debug_module_bkpt & ~cmd_valid |=>
    ccr_i_clear & mode == OMC_ST_WAIT & ~cpu_clk_en & sys_clk_en)
    else $error("wait entry wrong");
  a_wait_status_err: assert property (@(posedge ref_clk) disable iff (srst)
    ce & mode == OMC_ST_WAIT & cmd_valid & cmd_code == OMC_CMD_MEM_STAT
    |=> cmd_err & ~cmd_done)
    else $error("status command in wait gave no error");
  a_stop_illegal: assert property (@(posedge ref_clk) disable iff (srst)
    ce & mode == OMC_ST_RUN & stop_instr & ~stop_en & ~wait_instr
    & reset_pin_n & ~break_to_debug_instruction & ~cmd_valid
    & ~debug_controller_bkpt & ~on_chip_debug_module_bkpt |=>
    illegal_op_reset & mode == OMC_ST_RESET)
    else $error("stop without enable not turned into reset");
  a_stop2_latch: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(mode == OMC_ST_STOP2) |-> pins_latched & power_down
    & ~sys_clk_en & pin_out == $past(pin_out))
    else $error("stop2 entry did not latch pins");
  a_latch_hold: assert property (@(posedge ref_clk) disable iff (srst)
    pins_latched & ~(ce & ack_wr) |=> pins_latched
    & pin_out == $past(pin_out))
    else $error("latched pins moved before acknowledge");
  a_stop2_wake_flag: assert property (@(posedge ref_clk) disable iff (srst)
    ce & mode == OMC_ST_STOP2 & reset_pin_n & ~ext_irq_pin |=>
    por_restart & powerdown_flag & pins_latched
    & mode == OMC_ST_RESET)
    else $error("stop2 wake did not restart with flag");
  a_stop3_sel: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(mode == OMC_ST_STOP3) |-> $past(~goto_stop2) & ~osc_en
    & ~power_down)
    else $error("stop3 entered while stop2 selected");
endmodule : omc_top

// ### tb/omc_dbg_host.sv
// debug host model: issues decoded serial debug commands
module omc_dbg_host (
  // clock
  input wire logic ref_clk,
  // command strobe
  output logic cmd_valid,
  output omc_pkg::omc_cmd_t cmd_code
);
  timeunit 1ns;
  timeprecision 1ps;
  import omc_pkg::*;
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code = OMC_CMD_GO;
  end
  // idle gives a slow host; the bench picks which commands go in which mode
  task send(input omc_cmd_t c, input int idle);
    repeat (idle) @(posedge ref_clk);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    // stale code is inverted so it never passes for the last one
    cmd_code <= omc_cmd_t'(~c);
    #1;
  endtask : send
endmodule : omc_dbg_host

// ### tb/operating_mode_controller_tb.sv
// self-checking testbench of the operating mode controller
module operating_mode_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import omc_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic msp = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [2:0] brk = 3'h0;
  logic wait_instr = 1'b0;
  logic stop_instr = 1'b0;
  logic irq_req = 1'b0;
  logic ext_irq_pin = 1'b1;
  logic rpn = 1'b1;
  logic [4:0] wk = 5'h0;
  logic [15:0] irq_vec = 16'h0;
  logic [7:0] pin_drive = 8'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, cmd_valid, cmd_done, cmd_err, trace_step;
  logic cpu_clk_en, sys_clk_en, dbg_clk_en, osc_en, power_down, pwo;
  logic pins_latched, powerdown_flag, ccr_i_clear, int_stack_start;
  logic vec_fetch, illegal_op_reset, por_restart;
  logic [7:0] pin_out;
  logic [15:0] vec_addr;
  omc_cmd_t cmd_code;
  omc_mode_t mode;
  int bad_count = 0;
  int checks_done = 0;
  int seed = 32'h8486f9a0;
  int i;
  logic [31:0] rd;
  logic [7:0] p0;

  omc_top dut (.ref_clk(ref_clk), .srst(srst), .ce(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .reset_pin_n(rpn), .mode_select_pin(msp),
    .break_to_debug_instruction(brk[0]), .debug_controller_bkpt(brk[1]),
    .on_chip_debug_module_bkpt(brk[2]), .wait_instr(wait_instr),
    .stop_instr(stop_instr), .irq_req(irq_req), .irq_vec(irq_vec),
    .ext_irq_pin(ext_irq_pin), .keypad_interrupt_pins(wk[0]),
    .sci_rx_wake(wk[1]), .adc_wake(wk[2]), .lowvolt_interrupt(wk[3]),
    .periodic_wake_interrupt(wk[4]), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_done(cmd_done), .cmd_err(cmd_err),
    .trace_step(trace_step), .pin_drive(pin_drive), .pin_out(pin_out),
    .mode(mode), .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en),
    .dbg_clk_en(dbg_clk_en), .osc_en(osc_en), .power_down(power_down),
    .periodic_wake_osc_en(pwo), .pins_latched(pins_latched),
    .powerdown_flag(powerdown_flag), .ccr_i_clear(ccr_i_clear),
    .int_stack_start(int_stack_start), .vec_fetch(vec_fetch),
    .vec_addr(vec_addr), .illegal_op_reset(illegal_op_reset),
    .por_restart(por_restart));
  omc_dbg_host host (.ref_clk(ref_clk), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code));

  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  task give_verdict;
    if (bad_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  task chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk

  // k 0..2 break sources, 3 wait, 4 stop; outputs settle one edge later
  task ev(input int k);
    @(posedge ref_clk);
    if (k < 3)
      brk[k] <= 1'b1;
    wait_instr <= (k == 3);
    stop_instr <= (k == 4);
    @(posedge ref_clk);
    brk <= 3'h0;
    wait_instr <= 1'b0;
    stop_instr <= 1'b0;
    #1;
  endtask : ev

  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    for (n = 0; n < 20; n++)
    begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 20)
    begin
      chk(1'b0, "bus timeout");
      give_verdict();
    end
    #1;
  endtask : bus

  task rst(input logic v);
    int n;
    msp <= v;
    srst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    for (n = 0; n < 20 && mode === OMC_ST_RESET; n++)
    begin
      @(posedge ref_clk);
      #1;
    end
  endtask : rst

  initial
  begin
    rst(1'b1);
    chk(mode === OMC_ST_RUN && vec_fetch === 1'b1, "run entry");
    chk(vec_addr === 16'hfffe, "reset vector");
    bus(1'b1, 4'h8, 32'hff);
    bus(1'b0, 4'h8, 32'h0);
    chk(rd === 32'h0, "unmapped read");
    bus(1'b0, 4'h0, 32'h0);
    chk(rd === 32'h0, "control reset value");
    host.send(OMC_CMD_GO, 0);
    chk(cmd_done === 1'b0 && mode === OMC_ST_RUN, "go in run");
    for (i = 0; i < 4; i++)
    begin
      host.send(omc_cmd_t'(i), i);
      chk(cmd_done === 1'b1, "non-intrusive in run");
    end
    chk(mode === OMC_ST_DEBUG_SERIAL_PIN, "background command");
    for (i = 0; i < 6; i++)
    begin
      host.send(omc_cmd_t'(i), 0);
      chk(cmd_done === 1'b1 && mode === OMC_ST_DEBUG_SERIAL_PIN, "debug_serial_pin cmd");
      chk(trace_step === (i == 5), "trace step");
    end
    host.send(OMC_CMD_GO, 0);
    chk(cmd_done === 1'b1 && mode === OMC_ST_RUN, "go");
    for (i = 0; i < 3; i++)
    begin
      ev(i);
      chk(mode === OMC_ST_DEBUG_SERIAL_PIN, "break entry");
      host.send(OMC_CMD_GO, 1);
    end
    ev(3);
    chk(mode === OMC_ST_WAIT && cpu_clk_en === 1'b0, "wait");
    chk(sys_clk_en === 1'b1 && ccr_i_clear === 1'b1, "wait clocks");
    host.send(OMC_CMD_MEM, 0);
    chk(cmd_done === 1'b0 && cmd_err === 1'b0, "mem in wait");
    host.send(OMC_CMD_MEM_STAT, 0);
    chk(cmd_err === 1'b1, "status in wait");
    @(posedge ref_clk);
    irq_req <= 1'b1;
    @(posedge ref_clk);
    irq_req <= 1'b0;
    #1;
    chk(mode === OMC_ST_RUN && int_stack_start === 1'b1, "irq wake");
    ev(3);
    host.send(OMC_CMD_BACKGROUND, 2);
    chk(mode === OMC_ST_DEBUG_SERIAL_PIN, "wait to debug_serial_pin");
    host.send(OMC_CMD_GO, 0);
    ev(4);
    chk(illegal_op_reset === 1'b1, "stop disabled");
    chk(mode !== OMC_ST_STOP2 && mode !== OMC_ST_STOP3, "no stop");
    rst(1'b1);
    p0 = 8'($random(seed));
    pin_drive <= p0;
    bus(1'b1, 4'h0, 32'h03);
    chk(pwo === 1'b0, "wake source off");
    ev(4);
    chk(mode === OMC_ST_STOP2 && pins_latched === 1'b1, "stop2");
    chk(power_down === 1'b1 && osc_en === 1'b0, "stop2 power");
    @(posedge ref_clk);
    pin_drive <= ~p0;
    wk <= 5'h11;
    @(posedge ref_clk);
    wk <= 5'h0;
    #1;
    chk(mode === OMC_ST_STOP2 && pin_out === p0, "no stop2 wake");
    @(posedge ref_clk);
    ext_irq_pin <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk(mode === OMC_ST_RESET && por_restart === 1'b1, "stop2 exit");
    chk(powerdown_flag === 1'b1, "flag set");
    @(posedge ref_clk);
    ext_irq_pin <= 1'b1;
    #1;
    chk(mode === OMC_ST_RUN && vec_fetch === 1'b1, "restart");
    chk(vec_addr === 16'hfffe && pin_out === p0, "latched restart");
    bus(1'b0, 4'h4, 32'h0);
    chk(rd === 32'h13, "status after wake");
    bus(1'b0, 4'h0, 32'h0);
    chk(rd === 32'h0, "control defaulted");
    bus(1'b1, 4'h4, 32'h1);
    chk(powerdown_flag === 1'b0 && pins_latched === 1'b0, "ack");
    @(posedge ref_clk);
    #1;
    chk(pin_out === ~p0, "pins follow drive");
    for (i = 0; i < 5; i++)
    begin
      bus(1'b1, 4'h0, 32'h2f);
      chk(pwo === 1'b1, "wake source on");
      irq_vec <= 16'($random(seed));
      ev(4);
      chk(mode === OMC_ST_STOP3 && osc_en === 1'b0, "stop3");
      @(posedge ref_clk);
      wk[i] <= 1'b1;
      @(posedge ref_clk);
      wk <= 5'h0;
      #1;
      chk(mode === OMC_ST_RUN && vec_fetch === 1'b1, "stop3 wake");
      chk(vec_addr === irq_vec, "wake vector");
    end
    bus(1'b1, 4'h0, 32'h13);
    ev(4);
    chk(mode === OMC_ST_STOP3 && dbg_clk_en === 1'b1, "debug stop");
    host.send(OMC_CMD_BACKGROUND, 0);
    chk(mode === OMC_ST_DEBUG_SERIAL_PIN, "stop to debug_serial_pin");
    host.send(OMC_CMD_GO, 0);
    // reset pin exit from stop3 (debug on), then from stop2
    for (i = 0; i < 2; i++)
    begin
      bus(1'b1, 4'h0, (i == 0) ? 32'h13 : 32'h03);
      ev(4);
      chk(mode === (i == 0 ? OMC_ST_STOP3 : OMC_ST_STOP2), "stop");
      @(posedge ref_clk);
      rpn <= 1'b0;
      @(posedge ref_clk);
      rpn <= 1'b1;
      #1;
      chk(mode === OMC_ST_RESET, "reset pin exit");
      chk(powerdown_flag === (i == 1), "reset pin flag");
      @(posedge ref_clk);
      #1;
      chk(mode === OMC_ST_RUN && vec_addr === 16'hfffe, "pin vector");
      chk(vec_fetch === 1'b1, "reset pin fetch");
    end
    rst(1'b0);
    chk(mode === OMC_ST_DEBUG_SERIAL_PIN && vec_fetch === 1'b0, "pin low");
    give_verdict();
  end

  initial
  begin
    #400000;
    chk(1'b0, "run timeout");
    give_verdict();
  end
endmodule : operating_mode_controller_tb
